// >>> include/ddcw_defs.svh
// Shared constants for the display identification two-wire link
// Notes on behaviour
// - select byte is 1010, three ignored bits, direction
// - slave acknowledges address and data bytes on ninth clock; select only if type matches and not busy
// - master does not acknowledge read bytes; ninth clock released
// - master ends every transfer with STOP
// - write ignored if guard low at start
// - write aborted whenever guard drops mid-operation
// - guard pin per variant; ignored in transmit-only mode
// - master raises guard before START, holds past STOP
// - guarded-off writes still acknowledged, nine clocks each
// - select not acknowledged during internal write cycle
// - master polls select after write to check
// - recovery variants enter transition state first
// - transition falls back without valid select in time
// - clock falling edge clears vsync count and timer
// - over 128 vsyncs or timeout reverts mode
// - valid START and select locks two-wire mode
// - powers up transmit-only; clock fall enters two-wire
// - non-recovery variants stay two-wire until power-off
// - seven select bits MSB first, direction, acknowledge
`ifndef DDCW_DEFS_SVH
`define DDCW_DEFS_SVH
`define DDCW_DEV_TYPE       4'ha
`define DDCW_BITS_PER_BYTE  4'd8
`define DDCW_LAST_DATA_BIT  4'd7
`define DDCW_MEM_BYTES      128
`define DDCW_PAGE_BYTES     8
`define DDCW_VSYNC_LIMIT    8'd128
`define DDCW_VSYNC_MAX      8'hff
`define DDCW_RECOVERY_NS    64'd2000000000
`define DDCW_LINK_PERIOD_NS 64'd64
`define DDCW_REF_PERIOD_NS  10
`define DDCW_SCL_PERIOD_NS  2500
`define DDCW_WRITE_CYCLES   1000
`define DDCW_LINE_IDLE      2'b11
`define DDCW_OP_POLL        2'd0
`define DDCW_OP_SETADDR     2'd1
`define DDCW_OP_WRITE       2'd2
`define DDCW_OP_READ        2'd3
`endif

// >>> include/ddcw_pkg.sv
// Types shared by both ends of the two-wire link
`include "ddcw_defs.svh"
package ddcw_pkg;

  typedef enum logic [2:0] {
    mode_tx_only    = 3'b001,
    mode_transition = 3'b010,
    mode_locked     = 3'b100
  } ddcw_mode_e;

  typedef enum logic [8:0] {
    prot_idle     = 9'h001,
    prot_sel      = 9'h002,
    prot_sel_ack  = 9'h004,
    prot_addr     = 9'h008,
    prot_addr_ack = 9'h010,
    prot_wdata    = 9'h020,
    prot_wack     = 9'h040,
    prot_rdata    = 9'h080,
    prot_rack     = 9'h100
  } ddcw_prot_e;

  typedef enum logic [3:0] {
    host_idle  = 4'h1,
    host_start = 4'h2,
    host_bit   = 4'h4,
    host_stop  = 4'h8
  } ddcw_host_e;

  typedef struct packed {
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic [1:0]  wg_sync;
    logic [1:0]  vs_sync;
    logic        scl_d;
    logic        sda_d;
    logic        vs_d;
    ddcw_mode_e  mode;
    logic        two_wire;
    ddcw_prot_e  prot;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic        rw;
    logic [6:0]  addr;
    logic [6:0]  base;
    logic [3:0]  wr_cnt;
    logic        wr_ok;
    logic        ack_rx;
    logic        sda_en;
    logic [7:0]  vs_cnt;
    logic [31:0] to_cnt;
    logic [15:0] busy_cnt;
    logic        busy;
    logic        commit_tgl;
    logic [`DDCW_PAGE_BYTES-1:0][7:0] page;
    logic [`DDCW_MEM_BYTES-1:0][7:0]  mem;
  } ddcw_dev_s;

  typedef struct packed {
    logic [1:0] mode_sync;
    logic [1:0] busy_sync;
    logic [2:0] tgl_sync;
    logic       done;
  } ddcw_usr_s;

  typedef struct packed {
    logic [1:0]  sda_sync;
    ddcw_host_e  state;
    logic [1:0]  qph;
    logic [15:0] qcnt;
    logic [3:0]  bit_cnt;
    logic [1:0]  byte_idx;
    logic [1:0]  op;
    logic [6:0]  addr;
    logic [7:0]  data;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic        ackbit;
    logic        scl_en;
    logic        sda_en;
    logic        guard_want;
    logic        guard;
    logic        vsync;
    logic        rsp_valid;
    logic        rsp_ack;
    logic [7:0]  rsp_data;
  } ddcw_host_s;

endpackage

// >>> include/ddcw_link_if.sv
// Open-drain two-wire link plus guard and vertical sync wires
interface ddcw_link_if;
  logic host_scl_val;
  logic host_scl_en;
  logic host_sda_val;
  logic host_sda_en;
  logic dev_sda_val;
  logic dev_sda_en;
  logic write_guard;
  logic vertical_sync_clock;
  logic scl;
  logic sda;

  // Pull-ups make a released line read high
  assign scl = host_scl_en ? host_scl_val : 1'b1;
  assign sda = (host_sda_en ? host_sda_val : 1'b1) &
               (dev_sda_en ? dev_sda_val : 1'b1);

  modport host (
    output host_scl_val, host_scl_en, host_sda_val, host_sda_en,
    output write_guard, vertical_sync_clock,
    input  scl, sda
  );
  modport dev (
    output dev_sda_val, dev_sda_en,
    input  scl, sda, write_guard, vertical_sync_clock
  );
endinterface

// >>> rtl/ddcw_device.sv
// Memory slave end: select decode, write guard, mode recovery
`include "ddcw_defs.svh"
module ddcw_device #(
  parameter bit          RECOVERY_EN     = 1'b1,
  parameter bit          GUARD_ON_VSYNC  = 1'b0,
  parameter int unsigned RECOVERY_CYCLES =
    32'(`DDCW_RECOVERY_NS / `DDCW_LINK_PERIOD_NS),
  parameter int unsigned WRITE_CYCLES    = `DDCW_WRITE_CYCLES
) (
  // Link side
  ddcw_link_if.dev  lnk,
  input  wire logic link_clk,
  // User side
  input  wire logic ref_clk,
  input  wire logic resetn,
  output logic      two_wire_mode,
  output logic      write_busy,
  output logic      write_done
);

  ddcw_pkg::ddcw_dev_s s;
  ddcw_pkg::ddcw_dev_s next_s;
  ddcw_pkg::ddcw_usr_s u;
  ddcw_pkg::ddcw_usr_s next_u;

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic vs_rise;
  logic sda_s;
  logic guard;

  function automatic logic [6:0] page_slot(input logic [6:0] base,
                                           input logic [2:0] slot);
    logic [2:0] lo;
    lo = base[2:0] + slot;
    return {base[6:3], lo};
  endfunction

  always_comb begin
    next_s = s;
    next_s.scl_sync = {s.scl_sync[0], lnk.scl};
    next_s.sda_sync = {s.sda_sync[0], lnk.sda};
    next_s.wg_sync  = {s.wg_sync[0], lnk.write_guard};
    next_s.vs_sync  = {s.vs_sync[0], lnk.vertical_sync_clock};
    next_s.scl_d    = s.scl_sync[1];
    next_s.sda_d    = s.sda_sync[1];
    next_s.vs_d     = s.vs_sync[1];
    sda_s    = s.sda_sync[1];
    scl_rise = s.scl_sync[1] & ~s.scl_d;
    scl_fall = ~s.scl_sync[1] & s.scl_d;
    start_c  = s.scl_sync[1] & s.scl_d & s.sda_d & ~sda_s;
    stop_c   = s.scl_sync[1] & s.scl_d & ~s.sda_d & sda_s;
    vs_rise  = s.vs_sync[1] & ~s.vs_d;
    // Shared pin variants take the guard from the vsync input
    guard    = GUARD_ON_VSYNC ? s.vs_sync[1] : s.wg_sync[1];

    if (s.busy_cnt != 16'h0000) begin
      next_s.busy_cnt = s.busy_cnt - 16'h0001;
    end

    case (s.mode)
      ddcw_pkg::mode_tx_only: begin
        if (scl_fall) begin
          next_s.mode   = RECOVERY_EN ? ddcw_pkg::mode_transition
                                      : ddcw_pkg::mode_locked;
          next_s.vs_cnt = 8'h00;
          next_s.to_cnt = 32'h0;
        end
      end
      ddcw_pkg::mode_transition: begin
        if (scl_fall) begin
          next_s.vs_cnt = 8'h00;
          next_s.to_cnt = 32'h0;
        end else begin
          next_s.to_cnt = s.to_cnt + 32'h1;
          if (vs_rise && s.vs_cnt != `DDCW_VSYNC_MAX) begin
            next_s.vs_cnt = s.vs_cnt + 8'h01;
          end
        end
        if (s.vs_cnt > `DDCW_VSYNC_LIMIT ||
            s.to_cnt >= RECOVERY_CYCLES) begin
          next_s.mode = ddcw_pkg::mode_tx_only;
          next_s.prot = ddcw_pkg::prot_idle;
        end
      end
      ddcw_pkg::mode_locked: ;
      default: next_s.mode = ddcw_pkg::mode_tx_only;
    endcase

    // Any guard drop during an operation spoils the write
    if (s.prot != ddcw_pkg::prot_idle && !guard) begin
      next_s.wr_ok = 1'b0;
    end

    if (start_c) begin
      next_s.prot    = ddcw_pkg::prot_sel;
      next_s.bit_cnt = 4'h0;
      next_s.wr_cnt  = 4'h0;
      next_s.wr_ok   = guard;
      next_s.sda_en  = 1'b0;
    end else if (stop_c) begin
      if (s.prot == ddcw_pkg::prot_wdata && s.wr_ok && guard &&
          s.wr_cnt != 4'h0 && s.two_wire) begin
        for (int i = 0; i < `DDCW_PAGE_BYTES; i++) begin
          if (4'(i) < s.wr_cnt) begin
            next_s.mem[page_slot(s.base, 3'(i))] = s.page[i];
          end
        end
        next_s.busy_cnt   = 16'(WRITE_CYCLES);
        next_s.commit_tgl = ~s.commit_tgl;
      end
      next_s.prot   = ddcw_pkg::prot_idle;
      next_s.sda_en = 1'b0;
    end else begin
      case (s.prot)
        ddcw_pkg::prot_idle: ;
        ddcw_pkg::prot_sel,
        ddcw_pkg::prot_addr,
        ddcw_pkg::prot_wdata: begin
          if (scl_rise) begin
            next_s.shift   = {s.shift[6:0], sda_s};
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end
          if (scl_fall && s.bit_cnt == `DDCW_BITS_PER_BYTE) begin
            next_s.bit_cnt = 4'h0;
            next_s.sda_en  = 1'b1;
            if (s.prot == ddcw_pkg::prot_sel) begin
              if (s.shift[7:4] == `DDCW_DEV_TYPE) begin
                next_s.rw = s.shift[0];
                if (s.mode == ddcw_pkg::mode_transition) begin
                  next_s.mode = ddcw_pkg::mode_locked;
                end
              end
              if (s.shift[7:4] == `DDCW_DEV_TYPE && !s.busy) begin
                next_s.prot = ddcw_pkg::prot_sel_ack;
              end else begin
                next_s.sda_en = 1'b0;
                next_s.prot   = ddcw_pkg::prot_idle;
              end
            end else if (s.prot == ddcw_pkg::prot_addr) begin
              next_s.addr = s.shift[6:0];
              next_s.base = s.shift[6:0];
              next_s.prot = ddcw_pkg::prot_addr_ack;
            end else begin
              // Data kept even when unguarded; commit decides
              next_s.page[s.wr_cnt[2:0]] = s.shift;
              if (s.wr_cnt != `DDCW_BITS_PER_BYTE) begin
                next_s.wr_cnt = s.wr_cnt + 4'h1;
              end
              next_s.prot = ddcw_pkg::prot_wack;
            end
          end
        end
        ddcw_pkg::prot_sel_ack: begin
          if (scl_fall) begin
            if (s.rw) begin
              next_s.shift   = {s.mem[s.addr][6:0], 1'b0};
              next_s.sda_en  = ~s.mem[s.addr][7];
              next_s.bit_cnt = 4'h1;
              next_s.prot    = ddcw_pkg::prot_rdata;
            end else begin
              next_s.sda_en = 1'b0;
              next_s.prot   = ddcw_pkg::prot_addr;
            end
          end
        end
        ddcw_pkg::prot_addr_ack,
        ddcw_pkg::prot_wack: begin
          if (scl_fall) begin
            next_s.sda_en = 1'b0;
            next_s.prot   = ddcw_pkg::prot_wdata;
          end
        end
        ddcw_pkg::prot_rdata: begin
          if (scl_fall) begin
            if (s.bit_cnt == `DDCW_BITS_PER_BYTE) begin
              next_s.sda_en  = 1'b0;
              next_s.bit_cnt = 4'h0;
              next_s.addr    = s.addr + 7'h01;
              next_s.prot    = ddcw_pkg::prot_rack;
            end else begin
              next_s.sda_en  = ~s.shift[7];
              next_s.shift   = {s.shift[6:0], 1'b0};
              next_s.bit_cnt = s.bit_cnt + 4'h1;
            end
          end
        end
        ddcw_pkg::prot_rack: begin
          if (scl_rise) begin
            next_s.ack_rx = ~sda_s;
          end
          if (scl_fall) begin
            if (s.ack_rx) begin
              next_s.shift   = {s.mem[s.addr][6:0], 1'b0};
              next_s.sda_en  = ~s.mem[s.addr][7];
              next_s.bit_cnt = 4'h1;
              next_s.prot    = ddcw_pkg::prot_rdata;
            end else begin
              next_s.prot = ddcw_pkg::prot_idle;
            end
          end
        end
        default: next_s.prot = ddcw_pkg::prot_idle;
      endcase
    end

    // Never drive data in transmit-only mode; streaming is elsewhere
    next_s.two_wire = (next_s.mode != ddcw_pkg::mode_tx_only);
    if (!next_s.two_wire) begin
      next_s.sda_en = 1'b0;
    end
    next_s.busy = (next_s.busy_cnt != 16'h0000);
  end

  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      s          <= '0;
      s.scl_sync <= `DDCW_LINE_IDLE;
      s.sda_sync <= `DDCW_LINE_IDLE;
      s.scl_d    <= 1'b1;
      s.sda_d    <= 1'b1;
      s.mode     <= ddcw_pkg::mode_tx_only;
      s.prot     <= ddcw_pkg::prot_idle;
    end else begin
      s <= next_s;
    end
  end

  // Status into the user clock: levels by two flops, commits by toggle
  always_comb begin
    next_u           = u;
    next_u.mode_sync = {u.mode_sync[0], s.two_wire};
    next_u.busy_sync = {u.busy_sync[0], s.busy};
    next_u.tgl_sync  = {u.tgl_sync[1:0], s.commit_tgl};
    next_u.done      = u.tgl_sync[2] ^ u.tgl_sync[1];
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      u <= '0;
    end else begin
      u <= next_u;
    end
  end

  assign lnk.dev_sda_val = 1'b0;
  assign lnk.dev_sda_en  = s.sda_en;
  assign two_wire_mode   = u.mode_sync[1];
  assign write_busy      = u.busy_sync[1];
  assign write_done      = u.done;

endmodule

// >>> rtl/ddcw_host.sv
// Bus master end: clock divider, byte sequencer, guard control
`include "ddcw_defs.svh"
module ddcw_host #(
  parameter int unsigned QUARTER =
    (`DDCW_SCL_PERIOD_NS / 4) / `DDCW_REF_PERIOD_NS
) (
  // Link side
  ddcw_link_if.host lnk,
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Command
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic [1:0] cmd_op,
  input  wire logic [6:0] cmd_addr,
  input  wire logic [7:0] cmd_data,
  input  wire logic       guard_inhibit,
  input  wire logic       vsync_in,
  // Response
  output logic            rsp_valid,
  output logic            rsp_ack,
  output logic [7:0]      rsp_data
);

  ddcw_pkg::ddcw_host_s s;
  ddcw_pkg::ddcw_host_s next_s;
  logic tick;

  function automatic logic [7:0] tx_byte(input logic [1:0] op,
                                         input logic [1:0] idx,
                                         input logic [6:0] addr,
                                         input logic [7:0] data);
    logic rd;
    rd = (op == `DDCW_OP_READ);
    if (idx == 2'd0) begin
      return {`DDCW_DEV_TYPE, 3'b000, rd};
    end else if (idx == 2'd1) begin
      return rd ? 8'hff : {1'b0, addr};
    end
    return data;
  endfunction

  function automatic logic [1:0] byte_count(input logic [1:0] op);
    case (op)
      `DDCW_OP_POLL:  return 2'd1;
      `DDCW_OP_WRITE: return 2'd3;
      default:        return 2'd2;
    endcase
  endfunction

  always_comb begin
    next_s           = s;
    next_s.sda_sync  = {s.sda_sync[0], lnk.sda};
    next_s.rsp_valid = 1'b0;
    next_s.vsync     = vsync_in;
    next_s.guard     = s.guard_want & ~guard_inhibit;
    tick = (s.qcnt == 16'(QUARTER - 1));
    if (s.state != ddcw_pkg::host_idle) begin
      next_s.qcnt = tick ? 16'h0000 : s.qcnt + 16'h0001;
    end
    case (s.state)
      ddcw_pkg::host_idle: begin
        if (cmd_valid) begin
          next_s.op         = cmd_op;
          next_s.addr       = cmd_addr;
          next_s.data       = cmd_data;
          // Guard goes up a quarter bit before START
          next_s.guard_want = (cmd_op == `DDCW_OP_WRITE ||
                               cmd_op == `DDCW_OP_SETADDR);
          next_s.state      = ddcw_pkg::host_start;
          next_s.qph        = 2'd0;
          next_s.qcnt       = 16'h0000;
          next_s.byte_idx   = 2'd0;
          next_s.bit_cnt    = 4'h0;
          next_s.rx         = 8'h00;
          next_s.rsp_ack    = 1'b0;
        end
      end
      ddcw_pkg::host_start: begin
        if (tick) begin
          next_s.qph = s.qph + 2'd1;
          case (s.qph)
            2'd0: next_s.sda_en = 1'b1;
            2'd2: next_s.scl_en = 1'b1;
            2'd3: begin
              next_s.state  = ddcw_pkg::host_bit;
              next_s.tx     = tx_byte(s.op, 2'd0, s.addr, s.data);
              next_s.sda_en = ~next_s.tx[7];
            end
            default: ;
          endcase
        end
      end
      ddcw_pkg::host_bit: begin
        if (tick) begin
          next_s.qph = s.qph + 2'd1;
          case (s.qph)
            2'd0: next_s.scl_en = 1'b0;
            2'd2: begin
              if (s.bit_cnt == `DDCW_BITS_PER_BYTE) begin
                next_s.ackbit = ~s.sda_sync[1];
              end else begin
                next_s.rx = {s.rx[6:0], s.sda_sync[1]};
              end
              next_s.scl_en = 1'b1;
            end
            2'd3: begin
              if (s.bit_cnt != `DDCW_BITS_PER_BYTE) begin
                // Ones shift in, so the ack slot is released: NACK
                next_s.bit_cnt = s.bit_cnt + 4'h1;
                next_s.tx      = {s.tx[6:0], 1'b1};
                next_s.sda_en  = ~s.tx[6];
              end else begin
                if (s.byte_idx == 2'd0) begin
                  next_s.rsp_ack = s.ackbit;
                end
                if ((s.byte_idx == 2'd0 && !s.ackbit) ||
                    s.byte_idx + 2'd1 == byte_count(s.op)) begin
                  next_s.state  = ddcw_pkg::host_stop;
                  next_s.sda_en = 1'b1;
                end else begin
                  next_s.byte_idx = s.byte_idx + 2'd1;
                  next_s.bit_cnt  = 4'h0;
                  next_s.tx       = tx_byte(s.op, s.byte_idx + 2'd1,
                                            s.addr, s.data);
                  next_s.sda_en   = ~next_s.tx[7];
                end
              end
            end
            default: ;
          endcase
        end
      end
      ddcw_pkg::host_stop: begin
        if (tick) begin
          next_s.qph = s.qph + 2'd1;
          case (s.qph)
            2'd0: next_s.scl_en = 1'b0;
            2'd1: next_s.sda_en = 1'b0;
            2'd3: begin
              next_s.state      = ddcw_pkg::host_idle;
              next_s.guard_want = 1'b0;
              next_s.rsp_valid  = 1'b1;
              next_s.rsp_data   = s.rx;
            end
            default: ;
          endcase
        end
      end
      default: next_s.state = ddcw_pkg::host_idle;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s          <= '0;
      s.sda_sync <= `DDCW_LINE_IDLE;
      s.state    <= ddcw_pkg::host_idle;
    end else begin
      s <= next_s;
    end
  end

  assign lnk.host_scl_val        = 1'b0;
  assign lnk.host_scl_en         = s.scl_en;
  assign lnk.host_sda_val        = 1'b0;
  assign lnk.host_sda_en         = s.sda_en;
  assign lnk.write_guard         = s.guard;
  assign lnk.vertical_sync_clock = s.vsync;
  assign cmd_ready = (s.state == ddcw_pkg::host_idle);
  assign rsp_valid = s.rsp_valid;
  assign rsp_ack   = s.rsp_ack;
  assign rsp_data  = s.rsp_data;

endmodule

// >>> tb/ddcw_props.sv
// Concurrent checks on the link between host and memory device
module ddcw_props #(
  parameter int unsigned WRITE_CYCLES = 1000
) (
  // Clocks and reset
  input wire logic link_clk,
  input wire logic ref_clk,
  input wire logic resetn,
  // Link wires
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_en,
  input wire logic write_guard,
  // Device status
  input wire logic two_wire_mode,
  input wire logic write_busy,
  input wire logic write_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bench ratio: one link cycle is 6.4 reference cycles
  localparam int BUSY_MID = WRITE_CYCLES * 64 / 10;
  int   busy_len;
  int   since_fall;
  logic scl_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy_len <= 0;
    end else begin
      busy_len <= write_busy ? busy_len + 1 : 0;
    end
  end

  // Saturates so a long idle link cannot wrap
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      scl_q      <= 1'b1;
      since_fall <= 255;
    end else begin
      scl_q      <= scl;
      since_fall <= (scl_q && !scl) ? 0 :
                    since_fall + int'(since_fall < 255);
    end
  end

  quiet_txonly_a: assert property (
    @(posedge ref_clk) disable iff (!resetn) !two_wire_mode |-> !dev_sda_en)
    else $error("device drove data in transmit-only mode");
  mode_on_fall_a: assert property (
    @(posedge link_clk) disable iff (!resetn)
    $rose(two_wire_mode) |-> since_fall < 12)
    else $error("two-wire mode entered without clock fall");
  drive_low_a: assert property (
    @(posedge link_clk) disable iff (!resetn) $rose(dev_sda_en) |-> !scl)
    else $error("device took data line while clock high");
  hold_high_a: assert property (
    @(posedge link_clk) disable iff (!resetn)
    scl && $past(scl) |-> $stable(dev_sda_en))
    else $error("device changed data line while clock high");
  ack_width_a: assert property (
    @(posedge link_clk) disable iff (!resetn)
    $rose(dev_sda_en) |-> dev_sda_en[*8])
    else $error("device acknowledge too short");
  guard_idle_a: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    $rose(write_guard) |-> (scl && sda)[*8])
    else $error("guard raised while bus not idle");
  busy_no_ack_a: assert property (
    @(posedge ref_clk) disable iff (!resetn) write_busy |-> !dev_sda_en)
    else $error("device acknowledged during write cycle");
  busy_span_a: assert property (
    @(posedge ref_clk) disable iff (!resetn) $fell(write_busy) |->
    busy_len >= BUSY_MID - 5 && busy_len <= BUSY_MID + 5)
    else $error("write cycle length wrong");
  done_pulse_a: assert property (
    @(posedge ref_clk) disable iff (!resetn) write_done |=> !write_done)
    else $error("write done longer than one cycle");

  cover property (@(posedge ref_clk) $rose(write_busy));
  cover property (@(posedge ref_clk) $rose(two_wire_mode));
  cover property (@(posedge link_clk) $rose(dev_sda_en));
  cover property (@(posedge ref_clk) write_done);
endmodule

// >>> tb/tb_ddc2b_eeprom_slave_write_guard.sv
// Bench: host and device joined, plus a second device driven by hand
`define CHK(what, exp, got) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("ERROR %s expected %h seen %h", what, exp, got); \
  end \
end
module tb_ddc2b_eeprom_slave_write_guard;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q  = 32;
  localparam int WC = 400;
  localparam int RC = 2000;
  logic       ref_clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [6:0] cmd_addr = 7'h00;
  logic [7:0] cmd_data = 8'h00;
  logic       guard_inhibit = 1'b0;
  logic       vsync_in = 1'b0;
  logic       cmd_ready, rsp_valid, rsp_ack;
  logic [7:0] rsp_data;
  logic       two_wire_mode, write_busy, write_done, two_wire2;
  logic       ack_q = 1'b0;
  logic       bb_ack;
  logic [7:0] exp_rd [3] = '{8'ha5, 8'h00, 8'h00};
  int         err_count = 0;
  int         samples_checked = 0;
  int         acks = 0;
  int         dones = 0;
  int         got_acks;
  ddcw_link_if lnk ();
  ddcw_link_if lnk2 ();

  ddcw_host #(.QUARTER(Q)) ddcw_host_inst (
    .lnk(lnk.host), .ref_clk(ref_clk), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .guard_inhibit(guard_inhibit), .vsync_in(vsync_in),
    .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_data(rsp_data));
  ddcw_device #(.RECOVERY_CYCLES(RC), .WRITE_CYCLES(WC)) ddcw_device_inst (
    .lnk(lnk.dev), .link_clk(link_clk), .ref_clk(ref_clk),
    .resetn(resetn), .two_wire_mode(two_wire_mode),
    .write_busy(write_busy), .write_done(write_done));
  // Its link has no host, so faults and silences can be staged
  ddcw_device #(.RECOVERY_CYCLES(RC), .WRITE_CYCLES(WC)) ddcw_device_inst2 (
    .lnk(lnk2.dev), .link_clk(link_clk), .ref_clk(ref_clk),
    .resetn(resetn), .two_wire_mode(two_wire2), .write_busy(),
    .write_done());
  ddcw_props #(.WRITE_CYCLES(WC)) ddcw_props_inst (
    .link_clk(link_clk), .ref_clk(ref_clk), .resetn(resetn),
    .scl(lnk.scl), .sda(lnk.sda), .dev_sda_en(lnk.dev_sda_en),
    .write_guard(lnk.write_guard), .two_wire_mode(two_wire_mode),
    .write_busy(write_busy), .write_done(write_done));

  always #5 ref_clk = ~ref_clk;
  always #32 link_clk = ~link_clk;

  always @(posedge link_clk) begin
    ack_q <= lnk.dev_sda_en;
    if (lnk.dev_sda_en === 1'b1 && ack_q === 1'b0) acks++;
  end
  always @(posedge ref_clk) begin
    if (write_done === 1'b1) dones++;
  end

  task automatic qw(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic rst();
    resetn = 1'b0;
    repeat (6) @(posedge link_clk);
    qw(1);
    resetn = 1'b1;
    qw(40);
  endtask

  task automatic cmd(input logic [1:0] op, input logic [6:0] a,
                     input logic [7:0] d, input int cut);
    int a0;
    a0 = acks;
    qw(1);
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    qw(1);
    cmd_valid = 1'b0;
    `CHK("ready", 1'b0, cmd_ready)
    for (int n = 0; n < 20000 && rsp_valid !== 1'b1; n++) begin
      if (n == cut) guard_inhibit = 1'b1;
      qw(1);
    end
    `CHK("response", 1'b1, rsp_valid)
    `CHK("ready", 1'b1, cmd_ready)
    got_acks = acks - a0;
  endtask

  // START, one select byte with its ninth bit, then STOP
  task automatic bb_sel(input logic [7:0] b);
    logic [8:0] s;
    s = {b, 1'b1};
    lnk2.host_sda_en = 1'b1;
    qw(Q);
    lnk2.host_scl_en = 1'b1;
    for (int i = 0; i < 9; i++) begin
      lnk2.host_sda_en = ~s[8];
      s = s << 1;
      qw(Q);
      lnk2.host_scl_en = 1'b0;
      qw(Q);
      bb_ack = (lnk2.sda === 1'b0);
      qw(Q);
      lnk2.host_scl_en = 1'b1;
    end
    qw(Q);
    lnk2.host_sda_en = 1'b1;
    qw(Q);
    lnk2.host_scl_en = 1'b0;
    qw(Q);
    lnk2.host_sda_en = 1'b0;
    qw(Q);
  endtask

  task automatic sfall();
    lnk2.host_scl_en = 1'b1;
    qw(Q);
    lnk2.host_scl_en = 1'b0;
    qw(Q);
  endtask

  task automatic vs(input int n);
    repeat (n) begin
      lnk2.vertical_sync_clock = 1'b1;
      qw(Q);
      lnk2.vertical_sync_clock = 1'b0;
      qw(Q);
    end
  endtask

  task automatic complete_run();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    // Tests take about 760 us; stays under 100k reference cycles
    #950000;
    err_count++;
    complete_run();
  end

  initial begin
    lnk2.host_scl_val = 1'b0;
    lnk2.host_sda_val = 1'b0;
    lnk2.host_scl_en = 1'b0;
    lnk2.host_sda_en = 1'b0;
    lnk2.write_guard = 1'b0;
    lnk2.vertical_sync_clock = 1'b0;
    rst();
    `CHK("mode", 1'b0, two_wire_mode)
    sfall();
    `CHK("mode", 1'b1, two_wire2)
    repeat (1500) @(posedge link_clk);
    sfall();
    repeat (1500) @(posedge link_clk);
    qw(1);
    `CHK("mode", 1'b1, two_wire2)
    repeat (600) @(posedge link_clk);
    qw(1);
    `CHK("mode", 1'b0, two_wire2)
    rst();
    sfall();
    vs(128);
    `CHK("mode", 1'b1, two_wire2)
    vs(1);
    `CHK("mode", 1'b0, two_wire2)
    rst();
    bb_sel(8'h6a);
    `CHK("select ack", 1'b0, bb_ack)
    bb_sel(8'hac);
    `CHK("select ack", 1'b1, bb_ack)
    vs(130);
    `CHK("mode", 1'b1, two_wire2)
    cmd(2'h2, 7'h05, 8'ha5, -1);
    `CHK("byte acks", 3, got_acks)
    cmd(2'h0, 7'h00, 8'h00, -1);
    `CHK("poll ack", 1'b0, rsp_ack)
    for (int n = 0; n < 5000 && write_busy !== 1'b0; n++) qw(1);
    cmd(2'h0, 7'h00, 8'h00, -1);
    `CHK("poll ack", 1'b1, rsp_ack)
    `CHK("mode", 1'b1, two_wire_mode)
    // Vsync high must not stand in for the guard on this variant
    guard_inhibit = 1'b1;
    vsync_in = 1'b1;
    cmd(2'h2, 7'h06, 8'h3c, -1);
    `CHK("byte acks", 3, got_acks)
    cmd(2'h0, 7'h00, 8'h00, -1);
    `CHK("poll ack", 1'b1, rsp_ack)
    guard_inhibit = 1'b0;
    vsync_in = 1'b0;
    cmd(2'h2, 7'h07, 8'h77, Q * 60);
    guard_inhibit = 1'b0;
    cmd(2'h0, 7'h00, 8'h00, -1);
    `CHK("poll ack", 1'b1, rsp_ack)
    `CHK("writes", 1, dones)
    for (int i = 0; i < 3; i++) begin
      cmd(2'h1, 7'(5 + i), 8'h00, -1);
      cmd(2'h3, 7'h00, 8'h00, -1);
      `CHK("read data", exp_rd[i], rsp_data)
    end
    complete_run();
  end
endmodule
